// *** rtl/cad_defines.svh ***
// Opcode values and address constants for the address-mode decoder
`ifndef CAD_DEFINES_SVH
`define CAD_DEFINES_SVH
`define CAD_ZERO_PAGE 8'h00
`define CAD_OPC_STORE_ZERO_ZPG 8'h64
`define CAD_OPC_STORE_ZERO_ZPX 8'h74
`define CAD_OPC_STORE_ZERO_ABS 8'h9C
`define CAD_OPC_STORE_ZERO_ABX 8'h9E
`define CAD_OPC_TEST_RESET_BITS_ZPG 8'h14
`define CAD_OPC_TEST_RESET_BITS_ABS 8'h1C
`define CAD_OPC_TEST_SET_BITS_ZPG 8'h04
`define CAD_OPC_TEST_SET_BITS_ABS 8'h0C
`define CAD_OPC_BRANCH_ALWAYS 8'h80
`define CAD_OPC_PUSH_INDEX_X 8'hDA
`define CAD_OPC_PUSH_INDEX_Y 8'h5A
`define CAD_OPC_PULL_INDEX_X 8'hFA
`define CAD_OPC_PULL_INDEX_Y 8'h7A
`define CAD_OPC_INC_ACC 8'h1A
`define CAD_OPC_DECREMENT_ACC 8'h3A
`define CAD_OPC_JUMP_ABS 8'h4C
`define CAD_OPC_JUMP_IND 8'h6C
`define CAD_OPC_JUMP_INDX 8'h7C
`endif

// *** rtl/cad_pkg.sv ***
// Types shared by the address-mode decoder
package cad_pkg;
  typedef enum logic [3:0] {
    CAD_M_IMP, CAD_M_ACC, CAD_M_IMM, CAD_M_ZPG, CAD_M_ZPX, CAD_M_ZPY, CAD_M_ABS, CAD_M_ABX,
    CAD_M_ABY, CAD_M_REL, CAD_M_INDX, CAD_M_INDY, CAD_M_ZIND, CAD_M_AIND, CAD_M_AINDX
  } cad_mode_e;
  typedef enum logic [3:0] {
    CAD_OP_OTHER, CAD_OP_STORE_ZERO, CAD_OP_TEST_RESET_BITS, CAD_OP_TEST_SET_BITS,
    CAD_OP_BRANCH_ALWAYS, CAD_OP_PUSH_INDEX_X, CAD_OP_PUSH_INDEX_Y, CAD_OP_PULL_INDEX_X,
    CAD_OP_PULL_INDEX_Y, CAD_OP_INC_ACC, CAD_OP_DECREMENT, CAD_OP_JUMP
  } cad_op_e;
  typedef enum logic [2:0] {CAD_S_IDLE, CAD_S_PTR_LO, CAD_S_PTR_HI, CAD_S_RMW} cad_st_e;
  typedef struct packed {
    cad_st_e st;
    cad_mode_e mode;
    cad_op_e op;
    logic [15:0] ptr;
    logic [7:0] lo;
    logic [15:0] ea;
    logic [7:0] operand;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic rd;
    logic wr;
    logic taken;
    logic jump;
    logic zero;
  } cad_state_s;
endpackage

// *** rtl/cad_opcode_decode.sv ***
// Opcode to addressing mode and added-instruction decode
`timescale 1ns/1ps
`include "cad_defines.svh"
module cad_opcode_decode (
  input wire logic [7:0] opcode_i,
  output cad_pkg::cad_mode_e mode_o,
  output cad_pkg::cad_op_e op_o
);
  logic [3:0] row;
  logic [3:0] col;
  logic odd;
  assign row = opcode_i[7:4];
  assign col = opcode_i[3:0];
  assign odd = row[0];

  always_comb begin
    mode_o = cad_pkg::CAD_M_IMP;
    case (col)
      4'h0: begin
        if (odd || row == 4'h8) begin
          mode_o = cad_pkg::CAD_M_REL;
        end else if (row == 4'h2) begin
          mode_o = cad_pkg::CAD_M_ABS;
        end else if (row >= 4'hA) begin
          mode_o = cad_pkg::CAD_M_IMM;
        end
      end
      4'h1: mode_o = odd ? cad_pkg::CAD_M_INDY : cad_pkg::CAD_M_INDX;
      4'h2: begin
        if (odd) begin
          mode_o = cad_pkg::CAD_M_ZIND;
        end else if (row == 4'hA) begin
          mode_o = cad_pkg::CAD_M_IMM;
        end
      end
      // Row 1 holds the zero page bit-reset op, not an indexed form
      4'h4: mode_o = (odd && row != 4'h1) ? cad_pkg::CAD_M_ZPX : cad_pkg::CAD_M_ZPG;
      4'h5: mode_o = odd ? cad_pkg::CAD_M_ZPX : cad_pkg::CAD_M_ZPG;
      4'h6: begin
        if (row == 4'h9 || row == 4'hB) begin
          mode_o = cad_pkg::CAD_M_ZPY;
        end else begin
          mode_o = odd ? cad_pkg::CAD_M_ZPX : cad_pkg::CAD_M_ZPG;
        end
      end
      4'h9: mode_o = odd ? cad_pkg::CAD_M_ABY : cad_pkg::CAD_M_IMM;
      4'hA: mode_o = (row <= 4'h6 && (!odd || row <= 4'h3)) ? cad_pkg::CAD_M_ACC : cad_pkg::CAD_M_IMP;
      4'hC: begin
        if (row == 4'h6) begin
          mode_o = cad_pkg::CAD_M_AIND;
        end else if (row == 4'h7) begin
          mode_o = cad_pkg::CAD_M_AINDX;
        end else if (row == 4'h9) begin
          mode_o = cad_pkg::CAD_M_ABS;
        end else begin
          mode_o = (odd && row != 4'h1) ? cad_pkg::CAD_M_ABX : cad_pkg::CAD_M_ABS;
        end
      end
      4'hD: mode_o = odd ? cad_pkg::CAD_M_ABX : cad_pkg::CAD_M_ABS;
      4'hE: begin
        if (row == 4'hB) begin
          mode_o = cad_pkg::CAD_M_ABY;
        end else begin
          mode_o = odd ? cad_pkg::CAD_M_ABX : cad_pkg::CAD_M_ABS;
        end
      end
      default: mode_o = cad_pkg::CAD_M_IMP;
    endcase
  end

  always_comb begin
    case (opcode_i)
      `CAD_OPC_STORE_ZERO_ZPG, `CAD_OPC_STORE_ZERO_ZPX, `CAD_OPC_STORE_ZERO_ABS, `CAD_OPC_STORE_ZERO_ABX:
        op_o = cad_pkg::CAD_OP_STORE_ZERO;
      `CAD_OPC_TEST_RESET_BITS_ZPG, `CAD_OPC_TEST_RESET_BITS_ABS: op_o = cad_pkg::CAD_OP_TEST_RESET_BITS;
      `CAD_OPC_TEST_SET_BITS_ZPG, `CAD_OPC_TEST_SET_BITS_ABS: op_o = cad_pkg::CAD_OP_TEST_SET_BITS;
      `CAD_OPC_BRANCH_ALWAYS: op_o = cad_pkg::CAD_OP_BRANCH_ALWAYS;
      `CAD_OPC_PUSH_INDEX_X: op_o = cad_pkg::CAD_OP_PUSH_INDEX_X;
      `CAD_OPC_PUSH_INDEX_Y: op_o = cad_pkg::CAD_OP_PUSH_INDEX_Y;
      `CAD_OPC_PULL_INDEX_X: op_o = cad_pkg::CAD_OP_PULL_INDEX_X;
      `CAD_OPC_PULL_INDEX_Y: op_o = cad_pkg::CAD_OP_PULL_INDEX_Y;
      `CAD_OPC_INC_ACC: op_o = cad_pkg::CAD_OP_INC_ACC;
      `CAD_OPC_DECREMENT_ACC: op_o = cad_pkg::CAD_OP_DECREMENT;
      `CAD_OPC_JUMP_ABS, `CAD_OPC_JUMP_IND, `CAD_OPC_JUMP_INDX: op_o = cad_pkg::CAD_OP_JUMP;
      default: op_o = cad_pkg::CAD_OP_OTHER;
    endcase
  end
endmodule

// *** rtl/cad_address_mode_decode.sv ***
// Effective-address generation with pointer fetches and added-instruction handling
`timescale 1ns/1ps
`include "cad_defines.svh"
module cad_address_mode_decode (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] op_lo_i,
  input wire logic [7:0] op_hi_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] pc_next_i,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic busy_o,
  output logic done_o,
  output cad_pkg::cad_mode_e mode_o,
  output cad_pkg::cad_op_e op_o,
  output logic [15:0] ea_o,
  output logic [7:0] operand_o,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic taken_o,
  output logic jump_o,
  output logic zero_o
);
  cad_pkg::cad_state_s r;
  cad_pkg::cad_state_s n;
  cad_pkg::cad_mode_e dcd_mode;
  cad_pkg::cad_op_e dcd_op;
  logic [15:0] abs_base;
  logic [15:0] abx_sum;
  logic [15:0] aby_sum;
  logic [7:0] zpx_sum;
  logic [7:0] zpy_sum;
  logic [15:0] rel_sum;
  logic [15:0] ind_sum;
  logic [15:0] ea_v;
  logic [15:0] ptr_v;
  logic fin;
  logic go_rd;
  logic zp_ptr;

  cad_opcode_decode u_opc_dcd (
    .opcode_i(opcode_i),
    .mode_o(dcd_mode),
    .op_o(dcd_op)
  );

  assign abs_base = {op_hi_i, op_lo_i};
  assign abx_sum = abs_base + {8'h00, x_i};
  assign aby_sum = abs_base + {8'h00, y_i};
  assign zpx_sum = op_lo_i + x_i;
  assign zpy_sum = op_lo_i + y_i;
  // Sign-extend the displacement; wraps across the whole 64K space
  assign rel_sum = pc_next_i + {{8{op_lo_i[7]}}, op_lo_i};
  // Y joins the full 16-bit pointer value so its carry lands in the high byte
  assign ind_sum = {mem_rdata_i, r.lo} + {8'h00, y_i};
  assign zp_ptr = (r.mode == cad_pkg::CAD_M_INDX) || (r.mode == cad_pkg::CAD_M_INDY) ||
                  (r.mode == cad_pkg::CAD_M_ZIND);

  always_comb begin
    n = r;
    n.done = 1'b0;
    ea_v = r.ea;
    ptr_v = r.ptr;
    fin = 1'b0;
    go_rd = 1'b0;
    case (r.st)
      cad_pkg::CAD_S_IDLE: begin
        if (start_i) begin
          n.busy = 1'b1;
          n.mode = dcd_mode;
          n.op = dcd_op;
          n.operand = op_lo_i;
          n.wr = 1'b0;
          n.wdata = 8'h00;
          n.taken = 1'b0;
          n.jump = 1'b0;
          n.zero = 1'b0;
          case (dcd_mode)
            cad_pkg::CAD_M_ZPG: begin
              ea_v = {`CAD_ZERO_PAGE, op_lo_i};
              fin = 1'b1;
            end
            cad_pkg::CAD_M_ZPX: begin
              ea_v = {`CAD_ZERO_PAGE, zpx_sum};
              fin = 1'b1;
            end
            cad_pkg::CAD_M_ZPY: begin
              ea_v = {`CAD_ZERO_PAGE, zpy_sum};
              fin = 1'b1;
            end
            cad_pkg::CAD_M_ABS: begin
              ea_v = abs_base;
              fin = 1'b1;
            end
            cad_pkg::CAD_M_ABX: begin
              ea_v = abx_sum;
              fin = 1'b1;
            end
            cad_pkg::CAD_M_ABY: begin
              ea_v = aby_sum;
              fin = 1'b1;
            end
            cad_pkg::CAD_M_REL: begin
              ea_v = rel_sum;
              fin = 1'b1;
            end
            cad_pkg::CAD_M_INDX: begin
              ptr_v = {`CAD_ZERO_PAGE, zpx_sum};
              go_rd = 1'b1;
            end
            cad_pkg::CAD_M_INDY, cad_pkg::CAD_M_ZIND: begin
              ptr_v = {`CAD_ZERO_PAGE, op_lo_i};
              go_rd = 1'b1;
            end
            cad_pkg::CAD_M_AIND: begin
              ptr_v = abs_base;
              go_rd = 1'b1;
            end
            cad_pkg::CAD_M_AINDX: begin
              ptr_v = abx_sum;
              go_rd = 1'b1;
            end
            default: begin
              // Implied, accumulator and immediate need no operand access
              ea_v = 16'h0000;
              fin = 1'b1;
            end
          endcase
        end
      end
      cad_pkg::CAD_S_PTR_LO: begin
        if (mem_ack_i) begin
          n.lo = mem_rdata_i;
          n.st = cad_pkg::CAD_S_PTR_HI;
          // Page-zero pointers wrap inside page zero; 16-bit pointers carry into the page
          if (zp_ptr) begin
            n.addr = {`CAD_ZERO_PAGE, 8'(r.ptr[7:0] + 8'h01)};
          end else begin
            n.addr = r.ptr + 16'h0001;
          end
        end
      end
      cad_pkg::CAD_S_PTR_HI: begin
        if (mem_ack_i) begin
          ea_v = (r.mode == cad_pkg::CAD_M_INDY) ? ind_sum : {mem_rdata_i, r.lo};
          fin = 1'b1;
        end
      end
      cad_pkg::CAD_S_RMW: begin
        if (mem_ack_i) begin
          n.rd = 1'b0;
          n.st = cad_pkg::CAD_S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.wr = 1'b1;
          n.zero = (mem_rdata_i & acc_i) == 8'h00;
          if (r.op == cad_pkg::CAD_OP_TEST_SET_BITS) begin
            n.wdata = mem_rdata_i | acc_i;
          end else begin
            n.wdata = mem_rdata_i & ~acc_i;
          end
        end
      end
      default: n.st = cad_pkg::CAD_S_IDLE;
    endcase
    if (go_rd) begin
      n.ptr = ptr_v;
      n.addr = ptr_v;
      n.rd = 1'b1;
      n.st = cad_pkg::CAD_S_PTR_LO;
    end
    if (fin) begin
      n.ea = ea_v;
      n.jump = (n.op == cad_pkg::CAD_OP_JUMP);
      n.taken = (n.op == cad_pkg::CAD_OP_BRANCH_ALWAYS);
      // Bit test ops must read the target before they may write it
      if (n.op == cad_pkg::CAD_OP_TEST_SET_BITS || n.op == cad_pkg::CAD_OP_TEST_RESET_BITS) begin
        n.addr = ea_v;
        n.rd = 1'b1;
        n.st = cad_pkg::CAD_S_RMW;
      end else begin
        n.rd = 1'b0;
        n.st = cad_pkg::CAD_S_IDLE;
        n.busy = 1'b0;
        n.done = 1'b1;
        n.wr = (n.op == cad_pkg::CAD_OP_STORE_ZERO);
        n.wdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r <= cad_pkg::cad_state_s'('0);
    end else begin
      r <= n;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;
  assign mode_o = r.mode;
  assign op_o = r.op;
  assign ea_o = r.ea;
  assign operand_o = r.operand;
  assign mem_rd_o = r.rd;
  assign mem_addr_o = r.addr;
  assign wr_o = r.wr;
  assign wdata_o = r.wdata;
  assign taken_o = r.taken;
  assign jump_o = r.jump;
  assign zero_o = r.zero;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_abs_full_ea: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_ABS)
    |=> ea_o == {$past(op_hi_i), $past(op_lo_i)})
    else $error("absolute address not formed from operand bytes");
  a_zp_high_zero: assert property (done_o && (mode_o == cad_pkg::CAD_M_ZPG || mode_o == cad_pkg::CAD_M_ZPX)
    |-> ea_o[15:8] == 8'h00)
    else $error("zero page address left page zero");
  a_abx_index_sum: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_ABX)
    |=> done_o && ea_o == $past(abx_sum))
    else $error("absolute indexed address wrong");
  a_zpx_wrap_sum: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_ZPX)
    |=> ea_o == {8'h00, $past(zpx_sum)})
    else $error("zero page indexed address wrong");
  a_ptr_page_zero: assert property (mem_rd_o && r.st != cad_pkg::CAD_S_RMW && zp_ptr
    |-> mem_addr_o[15:8] == 8'h00)
    else $error("page-zero pointer fetched outside page zero");
  a_ptr_next_byte: assert property ((r.st == cad_pkg::CAD_S_PTR_LO && mem_ack_i && !zp_ptr)
    |=> mem_addr_o == $past(mem_addr_o) + 16'h0001)
    else $error("indirect high byte not at next location");
  a_rel_target: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_REL)
    |=> done_o && ea_o == $past(rel_sum))
    else $error("relative target wrong");
  a_store_zero_wr: assert property (done_o && op_o == cad_pkg::CAD_OP_STORE_ZERO |-> wr_o && wdata_o == 8'h00)
    else $error("store-zero did not write zero");
  a_set_bits_data: assert property ((r.st == cad_pkg::CAD_S_RMW && mem_ack_i && r.op == cad_pkg::CAD_OP_TEST_SET_BITS)
    |=> done_o && wr_o && wdata_o == ($past(mem_rdata_i) | $past(acc_i)))
    else $error("test-and-set data wrong");
  a_reset_bits_data: assert property ((r.st == cad_pkg::CAD_S_RMW && mem_ack_i && r.op == cad_pkg::CAD_OP_TEST_RESET_BITS)
    |=> done_o && wdata_o == ($past(mem_rdata_i) & ~$past(acc_i)))
    else $error("test-and-reset data wrong");
  a_always_taken: assert property (done_o && op_o == cad_pkg::CAD_OP_BRANCH_ALWAYS |-> taken_o && !jump_o)
    else $error("branch always not taken");
  a_indx_ptr_addr: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_INDX)
    |=> mem_rd_o && mem_addr_o == {8'h00, 8'($past(op_lo_i) + $past(x_i))})
    else $error("indexed indirect pointer address wrong");
  a_jump_indx_ptr: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_AINDX)
    |=> mem_rd_o && mem_addr_o == {$past(op_hi_i), $past(op_lo_i)} + {8'h00, $past(x_i)})
    else $error("jump indexed indirect pointer address wrong");
  a_indy_carry_sum: assert property ((r.st == cad_pkg::CAD_S_PTR_HI && mem_ack_i && r.mode == cad_pkg::CAD_M_INDY)
    |=> done_o && ea_o == {$past(mem_rdata_i), $past(r.lo)} + {8'h00, $past(y_i)})
    else $error("indirect indexed address wrong");
  a_zind_target: assert property ((r.st == cad_pkg::CAD_S_PTR_HI && mem_ack_i && r.mode == cad_pkg::CAD_M_ZIND)
    |=> done_o && ea_o == {$past(mem_rdata_i), $past(r.lo)})
    else $error("zero page indirect target wrong");
  a_imm_no_access: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_IMM)
    |=> done_o && !mem_rd_o && operand_o == $past(op_lo_i))
    else $error("immediate operand not taken from second byte");
  a_jump_abs_dest: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && opcode_i == `CAD_OPC_JUMP_ABS)
    |=> done_o && jump_o && ea_o == {$past(op_hi_i), $past(op_lo_i)})
    else $error("absolute jump target wrong");
  a_rel_only_branch: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && dcd_mode == cad_pkg::CAD_M_REL)
    |-> opcode_i[3:0] == 4'h0)
    else $error("relative mode decoded for a non-branch opcode");
  a_push_x_decode: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && opcode_i == `CAD_OPC_PUSH_INDEX_X)
    |=> done_o && op_o == cad_pkg::CAD_OP_PUSH_INDEX_X)
    else $error("push index x not decoded");
  a_pull_y_decode: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && opcode_i == `CAD_OPC_PULL_INDEX_Y)
    |=> done_o && op_o == cad_pkg::CAD_OP_PULL_INDEX_Y)
    else $error("pull index y not decoded");
  a_inc_acc_decode: assert property ((r.st == cad_pkg::CAD_S_IDLE && start_i && opcode_i == `CAD_OPC_INC_ACC)
    |=> op_o == cad_pkg::CAD_OP_INC_ACC && mode_o == cad_pkg::CAD_M_ACC)
    else $error("increment accumulator not decoded");
endmodule

// *** tb/cad_mem_model.sv ***
// Behavioural program and data memory answering the decoder's read requests
`timescale 1ns/1ps
module cad_mem_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [1:0] delay_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  logic [1:0] wait_r;
  // Data toggles outside the ack cycle so a late sample never looks valid
  always @(posedge clock_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_r <= 2'b00;
      mem_rdata_o <= 8'hA5;
    end else if (!mem_rd_i || mem_ack_o) begin
      mem_ack_o <= 1'b0;
      wait_r <= 2'b00;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (wait_r == delay_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3C;
    end else begin
      wait_r <= wait_r + 2'b01;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the address-mode decoder
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [7:0] opcode_i = 8'h00, op_lo_i = 8'h00, op_hi_i = 8'h00, x_i = 8'h00, y_i = 8'h00, acc_i = 8'h00;
  logic [15:0] pc_next_i = 16'h0000;
  logic [1:0] dly = 2'b00;
  logic mem_ack_i, mem_rd_o, busy_o, done_o, wr_o, taken_o, jump_o, zero_o;
  logic [7:0] mem_rdata_i, operand_o, wdata_o;
  logic [15:0] ea_o, mem_addr_o;
  cad_pkg::cad_mode_e mode_o;
  cad_pkg::cad_op_e op_o;
  int fail_count = 0;
  int cmp_count = 0;
  localparam logic [7:0] OPS [29] = '{8'hA5, 8'hB5, 8'hB6, 8'hAD, 8'hBD, 8'hB9, 8'hA1, 8'hB1, 8'hB2, 8'h6C,
    8'h7C, 8'h4C, 8'h80, 8'hF0, 8'hA9, 8'h64, 8'h74, 8'h9C, 8'h9E, 8'h04, 8'h0C, 8'h14, 8'h1C, 8'hDA, 8'h5A,
    8'hFA, 8'h7A, 8'h1A, 8'h3A};

  always #10 clock_i = ~clock_i;

  cad_address_mode_decode i_dut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i),
    .op_lo_i(op_lo_i), .op_hi_i(op_hi_i), .x_i(x_i), .y_i(y_i), .acc_i(acc_i), .pc_next_i(pc_next_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .mode_o(mode_o),
    .op_o(op_o), .ea_o(ea_o), .operand_o(operand_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .wr_o(wr_o), .wdata_o(wdata_o), .taken_o(taken_o), .jump_o(jump_o), .zero_o(zero_o));

  cad_mem_model i_mem (.clock_i(clock_i), .rst_i(rst_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
    .delay_i(dly), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Page-zero pointer pair wraps inside page zero
  function automatic logic [15:0] ptrz(input logic [7:0] p);
    return {mb({8'h00, 8'(p + 8'h01)}), mb({8'h00, p})};
  endfunction
  function automatic logic [15:0] ptr16(input logic [15:0] p);
    return {mb(p + 16'h0001), mb(p)};
  endfunction

  function automatic cad_pkg::cad_mode_e exp_mode(input logic [7:0] o);
    case (o)
      8'hA5, 8'h64, 8'h04, 8'h14: return cad_pkg::CAD_M_ZPG;
      8'hB5, 8'h74: return cad_pkg::CAD_M_ZPX;
      8'hB6: return cad_pkg::CAD_M_ZPY;
      8'hAD, 8'h4C, 8'h9C, 8'h0C, 8'h1C: return cad_pkg::CAD_M_ABS;
      8'hBD, 8'h9E: return cad_pkg::CAD_M_ABX;
      8'hB9: return cad_pkg::CAD_M_ABY;
      8'hA1: return cad_pkg::CAD_M_INDX;
      8'hB1: return cad_pkg::CAD_M_INDY;
      8'hB2: return cad_pkg::CAD_M_ZIND;
      8'h6C: return cad_pkg::CAD_M_AIND;
      8'h7C: return cad_pkg::CAD_M_AINDX;
      8'h80, 8'hF0: return cad_pkg::CAD_M_REL;
      8'hA9: return cad_pkg::CAD_M_IMM;
      8'h1A, 8'h3A: return cad_pkg::CAD_M_ACC;
      default: return cad_pkg::CAD_M_IMP;
    endcase
  endfunction

  function automatic cad_pkg::cad_op_e exp_op(input logic [7:0] o);
    case (o)
      8'h64, 8'h74, 8'h9C, 8'h9E: return cad_pkg::CAD_OP_STORE_ZERO;
      8'h14, 8'h1C: return cad_pkg::CAD_OP_TEST_RESET_BITS;
      8'h04, 8'h0C: return cad_pkg::CAD_OP_TEST_SET_BITS;
      8'h80: return cad_pkg::CAD_OP_BRANCH_ALWAYS;
      8'hDA: return cad_pkg::CAD_OP_PUSH_INDEX_X;
      8'h5A: return cad_pkg::CAD_OP_PUSH_INDEX_Y;
      8'hFA: return cad_pkg::CAD_OP_PULL_INDEX_X;
      8'h7A: return cad_pkg::CAD_OP_PULL_INDEX_Y;
      8'h1A: return cad_pkg::CAD_OP_INC_ACC;
      8'h3A: return cad_pkg::CAD_OP_DECREMENT;
      8'h4C, 8'h6C, 8'h7C: return cad_pkg::CAD_OP_JUMP;
      default: return cad_pkg::CAD_OP_OTHER;
    endcase
  endfunction

  function automatic logic [15:0] exp_ea(input cad_pkg::cad_mode_e m, input logic [7:0] lo, hi, xv, yv,
                                         input logic [15:0] pc);
    case (m)
      cad_pkg::CAD_M_ZPG: return {8'h00, lo};
      cad_pkg::CAD_M_ZPX: return {8'h00, 8'(lo + xv)};
      cad_pkg::CAD_M_ZPY: return {8'h00, 8'(lo + yv)};
      cad_pkg::CAD_M_ABS: return {hi, lo};
      cad_pkg::CAD_M_ABX: return {hi, lo} + {8'h00, xv};
      cad_pkg::CAD_M_ABY: return {hi, lo} + {8'h00, yv};
      cad_pkg::CAD_M_REL: return pc + {{8{lo[7]}}, lo};
      cad_pkg::CAD_M_INDX: return ptrz(8'(lo + xv));
      cad_pkg::CAD_M_INDY: return ptrz(lo) + {8'h00, yv};
      cad_pkg::CAD_M_ZIND: return ptrz(lo);
      cad_pkg::CAD_M_AIND: return ptr16({hi, lo});
      cad_pkg::CAD_M_AINDX: return ptr16({hi, lo} + {8'h00, xv});
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic run_op(input logic [7:0] opc, lo, hi, xv, yv);
    int n;
    logic [15:0] e;
    logic [7:0] m;
    cad_pkg::cad_op_e k;
    @(posedge clock_i);
    start_i <= 1'b1;
    opcode_i <= opc;
    op_lo_i <= lo;
    op_hi_i <= hi;
    x_i <= xv;
    y_i <= yv;
    acc_i <= 8'($urandom);
    pc_next_i <= 16'($urandom);
    dly <= 2'($urandom);
    @(posedge clock_i);
    start_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 100);
    e = exp_ea(exp_mode(opc), lo, hi, xv, yv, pc_next_i);
    m = mb(e);
    k = exp_op(opc);
    check("done", 16'(done_o), 16'h0001);
    check("busy", 16'(busy_o), 16'h0000);
    check("mode", 16'(mode_o), 16'(exp_mode(opc)));
    check("op", 16'(op_o), 16'(k));
    check("ea", ea_o, e);
    check("operand", 16'(operand_o), 16'(lo));
    check("taken", 16'(taken_o), 16'(opc == 8'h80));
    check("jump", 16'(jump_o), 16'(k == cad_pkg::CAD_OP_JUMP));
    check("write", 16'(wr_o), 16'(k inside {cad_pkg::CAD_OP_STORE_ZERO, cad_pkg::CAD_OP_TEST_RESET_BITS,
      cad_pkg::CAD_OP_TEST_SET_BITS}));
    if (k == cad_pkg::CAD_OP_STORE_ZERO)
      check("wdata", 16'(wdata_o), 16'h0000);
    if (k == cad_pkg::CAD_OP_TEST_RESET_BITS)
      check("wdata", 16'(wdata_o), 16'(m & ~acc_i));
    if (k == cad_pkg::CAD_OP_TEST_SET_BITS)
      check("wdata", 16'(wdata_o), 16'(m | acc_i));
    check("zero", 16'(zero_o), 16'((k == cad_pkg::CAD_OP_TEST_SET_BITS || k == cad_pkg::CAD_OP_TEST_RESET_BITS)
      && ((m & acc_i) == 8'h00)));
  endtask

  // Sized for 50000 cycles of traffic, well above the expected run of about a thousand
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h9787));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    run_op(8'hA1, 8'hFE, 8'h00, 8'h01, 8'h00);
    run_op(8'hA1, 8'hF0, 8'h77, 8'h30, 8'h00);
    run_op(8'hB5, 8'hF0, 8'h12, 8'h20, 8'h00);
    run_op(8'hB1, 8'hFF, 8'h00, 8'h00, 8'hFF);
    run_op(8'hB2, 8'hFF, 8'h00, 8'h00, 8'h00);
    run_op(8'h6C, 8'hFF, 8'h12, 8'h00, 8'h00);
    run_op(8'h7C, 8'hFF, 8'hFF, 8'h03, 8'h00);
    run_op(8'hBD, 8'hF0, 8'h12, 8'h20, 8'h00);
    run_op(8'h80, 8'h80, 8'h00, 8'h00, 8'h00);
    repeat (10)
      foreach (OPS[i])
        run_op(OPS[i], 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check("ea after reset", ea_o, 16'h0000);
    check("wr after reset", 16'(wr_o), 16'h0000);
    @(posedge clock_i);
    rst_i <= 1'b0;
    run_op(8'hAD, 8'h34, 8'hFF, 8'h00, 8'h00);
    wrap_up();
  end
endmodule
